// [hdl/hsw_core.sv]
// Health status word logic: builds the 16-bit health word, paces packets.
// Assumes status sources and host commands are on clk; utc_pps is a pin.
`include "hsw_defs.svh"

module hsw_core
    import hsw_pkg::*;
#(
    parameter int TICK_CYCLES = `HSW_UPDATE_PERIOD_NS / `HSW_CLK_PERIOD_NS,
    parameter int INIT_TICKS = `HSW_INIT_TIME_S * `HSW_UPDATE_HZ,
    parameter bit NAV_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Status sources and time reference
    input wire hsw_src_s src,
    input wire logic utc_pps,
    // Host configuration and commands
    input wire hsw_cfg_s cfg,
    input wire logic get_packet_cmd,
    input wire logic get_diag,
    // Register port view
    output logic [15:0] health_status_word,
    // Packet stream
    output logic pkt_valid,
    output logic [15:0] pkt_health,
    output logic diag_valid,
    output hsw_diag_s diag_packet,
    // Algorithm control
    output logic update_tick,
    output logic init_phase,
    output logic low_gain,
    output logic algo_restart
);

    localparam logic [15:0] TURN_THR_DEF =
        16'(`HSW_TURN_THR_MDPS / `HSW_RATE_LSB_MDPS);
    localparam logic [15:0] QUIET_THR =
        16'(`HSW_QUIET_THR_MDPS / `HSW_RATE_LSB_MDPS);

    hsw_state_e state;
    logic tick;
    logic [`HSW_INIT_W-1:0] init_cnt;
    logic [15:0] turn_thr;
    logic [5:0] rate_cnt;
    logic [5:0] rate_div;
    logic [15:0] yaw_mag;
    logic [2:0] axis_quiet;
    logic all_quiet;
    logic turning;
    logic rate_hit;
    logic [15:0] next_word;
    logic [3:0] alerts;

    hsw_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .utc_pps(utc_pps),
        .utc_valid(src.utc_valid),
        .tick(tick)
    );

    // Turn threshold, host may override the default
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            turn_thr <= TURN_THR_DEF;
        end else if (cfg.turn_thr_wr) begin
            turn_thr <= cfg.turn_thr;
        end
    end

    assign yaw_mag = src.yaw_rate[15] ? 16'(-src.yaw_rate) : src.yaw_rate;
    assign turning = cfg.turn_alert_en && (yaw_mag > turn_thr);

    // Per-axis quiet test on the low-passed rates
    generate
        for (genvar i = 0; i < 3; i++) begin : g_axis
            logic [15:0] mag;
            assign mag = src.lp_rate[i][15] ? 16'(-src.lp_rate[i])
                                            : src.lp_rate[i];
            assign axis_quiet[i] = (mag < QUIET_THR);
        end
    endgenerate

    assign all_quiet = &axis_quiet;

    // Algorithm phase: init with high gain, run, or fatal hold
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= HSW_ST_INIT;
        end else begin
            unique case (state)
                HSW_ST_INIT: begin
                    if (cfg.overrange_restart_enable && src.overrange) begin
                        state <= HSW_ST_HOLD;
                    end else if (tick && init_cnt ==
                                 `HSW_INIT_W'(INIT_TICKS - 1)) begin
                        state <= HSW_ST_RUN;
                    end
                end
                HSW_ST_RUN: begin
                    if (cfg.overrange_restart_enable && src.overrange) begin
                        state <= HSW_ST_HOLD;
                    end
                end
                HSW_ST_HOLD: begin
                    if (all_quiet && !src.overrange) begin
                        state <= HSW_ST_INIT;
                    end
                end
                default: state <= HSW_ST_INIT;
            endcase
        end
    end

    // Init phase counted in update ticks, cleared on every restart
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            init_cnt <= '0;
        end else if (state != HSW_ST_INIT) begin
            init_cnt <= '0;
        end else if (tick) begin
            init_cnt <= init_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            init_phase <= 1'b1;
            low_gain <= 1'b0;
            algo_restart <= 1'b0;
        end else begin
            init_phase <= (state != HSW_ST_RUN);
            low_gain <= (state == HSW_ST_RUN);
            algo_restart <= (state == HSW_ST_HOLD) && all_quiet
                            && !src.overrange;
        end
    end

    // Alert bits, ordered {sensor, sw, link, hw} to match the word
    always_comb begin
        alerts[0] = NAV_VARIANT ? !src.gps_acquired : 1'b0;
        alerts[1] = src.gps_comm_lost;
        alerts[2] = init_phase || src.high_gain || turning;
        alerts[3] = src.overrange;
    end

    // Health word, reserved bits forced low
    always_comb begin
        next_word = `HSW_WORD_RESET;
        next_word[`HSW_B_FATAL] = src.fatal_int
                                  || (state == HSW_ST_HOLD);
        next_word[`HSW_B_HW_FAULT] = src.hw_fault;
        next_word[`HSW_B_LINK_FAULT] = src.link_fault;
        next_word[`HSW_B_SW_FAULT] = src.sw_fault || src.mag_align_bad
                                     || !src.mag_cal_done;
        next_word[`HSW_B_HW_ALERT] = alerts[0];
        next_word[`HSW_B_LINK_ALERT] = alerts[1];
        next_word[`HSW_B_SW_ALERT] = alerts[2];
        next_word[`HSW_B_SENSOR_ALERT] = alerts[3];
        next_word[`HSW_B_ANY_ALERT] = |(alerts & cfg.alert_en);
        next_word = next_word & ~`HSW_RSVD_MASK;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            health_status_word <= `HSW_WORD_RESET;
        end else begin
            health_status_word <= next_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            update_tick <= 1'b0;
        end else begin
            update_tick <= tick;
        end
    end

    // Packet rate divisor from the host selection
    always_comb begin
        unique case (cfg.rate_sel)
            `HSW_RATE_100: rate_div = `HSW_DIV_100;
            `HSW_RATE_50: rate_div = `HSW_DIV_50;
            `HSW_RATE_25: rate_div = `HSW_DIV_25;
            `HSW_RATE_20: rate_div = `HSW_DIV_20;
            `HSW_RATE_10: rate_div = `HSW_DIV_10;
            `HSW_RATE_5: rate_div = `HSW_DIV_5;
            `HSW_RATE_2: rate_div = `HSW_DIV_2;
            `HSW_RATE_QUIET: rate_div = `HSW_DIV_100;
        endcase
    end

    // Greater-or-equal so a lowered divisor never stalls the stream
    assign rate_hit = tick && (rate_cnt >= rate_div - 6'h01);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rate_cnt <= '0;
        end else if (rate_hit) begin
            rate_cnt <= '0;
        end else if (tick) begin
            rate_cnt <= rate_cnt + 6'h01;
        end
    end

    // Measurement packets: paced, or polled in any rate mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pkt_valid <= 1'b0;
            pkt_health <= `HSW_WORD_RESET;
        end else begin
            pkt_valid <= (rate_hit && cfg.rate_sel != `HSW_RATE_QUIET)
                         || (get_packet_cmd && !get_diag);
            pkt_health <= next_word;
        end
    end

    // Diagnostic packet on a get-packet request for it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            diag_valid <= 1'b0;
            diag_packet <= '0;
        end else begin
            diag_valid <= get_packet_cmd && get_diag;
            if (get_packet_cmd && get_diag) begin
                diag_packet.health <= next_word;
                diag_packet.state <= state;
                diag_packet.mag_cal_done <= src.mag_cal_done;
                diag_packet.gps_acquired <= src.gps_acquired;
                diag_packet.turning <= turning;
                diag_packet.quiet <= all_quiet;
                diag_packet.init_phase <= init_phase;
            end
        end
    end

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        (health_status_word & `HSW_RSVD_MASK) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Reserved health bits not zero");

    property p_any_alert;
        @(posedge clk) disable iff (!rst_n)
        ##1 health_status_word[`HSW_B_ANY_ALERT] ==
            |(health_status_word[`HSW_B_SENSOR_ALERT:`HSW_B_HW_ALERT]
              & $past(cfg.alert_en));
    endproperty
    a_any_alert: assert property (p_any_alert)
        else $error("Summary alert does not match enabled alerts");

    property p_cal_missing;
        @(posedge clk) disable iff (!rst_n)
        !src.mag_cal_done |=> health_status_word[`HSW_B_SW_FAULT];
    endproperty
    a_cal_missing: assert property (p_cal_missing)
        else $error("Missing calibration not flagged");

    property p_hw_fault;
        @(posedge clk) disable iff (!rst_n)
        ##1 health_status_word[`HSW_B_HW_FAULT] == $past(src.hw_fault);
    endproperty
    a_hw_fault: assert property (p_hw_fault)
        else $error("Hardware fault bit wrong");

    property p_link_alert;
        @(posedge clk) disable iff (!rst_n)
        src.gps_comm_lost |=> health_status_word[`HSW_B_LINK_ALERT];
    endproperty
    a_link_alert: assert property (p_link_alert)
        else $error("Receiver link loss not flagged");

    property p_overrange;
        @(posedge clk) disable iff (!rst_n)
        src.overrange |=> health_status_word[`HSW_B_SENSOR_ALERT];
    endproperty
    a_overrange: assert property (p_overrange)
        else $error("Over-range not flagged");

    property p_fatal_hold;
        @(posedge clk) disable iff (!rst_n)
        cfg.overrange_restart_enable && src.overrange
        |=> ##1 health_status_word[`HSW_B_FATAL];
    endproperty
    a_fatal_hold: assert property (p_fatal_hold)
        else $error("Over-range restart did not raise fatal");

    property p_init_alert;
        @(posedge clk) disable iff (!rst_n)
        init_phase |=> health_status_word[`HSW_B_SW_ALERT];
    endproperty
    a_init_alert: assert property (p_init_alert)
        else $error("Init phase not shown in software alert");

    property p_quiet_mode;
        @(posedge clk) disable iff (!rst_n)
        cfg.rate_sel == `HSW_RATE_QUIET && !get_packet_cmd |=> !pkt_valid;
    endproperty
    a_quiet_mode: assert property (p_quiet_mode)
        else $error("Packet sent in quiet mode without request");

    property p_pkt_word;
        @(posedge clk) disable iff (!rst_n)
        pkt_valid |-> (pkt_health == health_status_word)
            && (pkt_health[`HSW_B_HW_FAULT] == $past(src.hw_fault))
            && (pkt_health[`HSW_B_LINK_FAULT] == $past(src.link_fault));
    endproperty
    a_pkt_word: assert property (p_pkt_word)
        else $error("Packet health differs from health word");

    property p_diag;
        @(posedge clk) disable iff (!rst_n)
        // A paced packet may share the cycle, but only on a tick
        get_packet_cmd && get_diag |=> diag_valid
            && (!pkt_valid || $past(tick));
    endproperty
    a_diag: assert property (p_diag)
        else $error("Diagnostic request not answered");

    c_pkt: cover property (@(posedge clk) disable iff (!rst_n) pkt_valid);
    c_diag: cover property (@(posedge clk) disable iff (!rst_n) diag_valid);
    c_restart: cover property (@(posedge clk) disable iff (!rst_n)
        algo_restart);
    c_run: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(low_gain));

endmodule

// [hdl/hsw_defs.svh]
// Numeric constants of the health status word logic.
// Assumes a 100 MHz processing clock and rates in 0.01 deg/s units.
`ifndef HSW_DEFS_SVH
`define HSW_DEFS_SVH

// Clock and cadence
`define HSW_CLK_PERIOD_NS 10
`define HSW_UPDATE_PERIOD_NS 10000000
`define HSW_UPDATE_HZ 100
`define HSW_INIT_TIME_S 60
`define HSW_TICK_W 20
`define HSW_INIT_W 13

// Rate scaling, thresholds in mdeg/s
`define HSW_RATE_LSB_MDPS 10
`define HSW_TURN_THR_MDPS 500
`define HSW_QUIET_THR_MDPS 3000

// Health word bit positions
`define HSW_B_FATAL 0
`define HSW_B_HW_FAULT 1
`define HSW_B_LINK_FAULT 2
`define HSW_B_SW_FAULT 3
`define HSW_B_ANY_ALERT 8
`define HSW_B_HW_ALERT 9
`define HSW_B_LINK_ALERT 10
`define HSW_B_SW_ALERT 11
`define HSW_B_SENSOR_ALERT 12
`define HSW_RSVD_MASK 16'hE0F0
`define HSW_WORD_RESET 16'h0000

// Packet rate select codes
`define HSW_RATE_100 3'h0
`define HSW_RATE_50 3'h1
`define HSW_RATE_25 3'h2
`define HSW_RATE_20 3'h3
`define HSW_RATE_10 3'h4
`define HSW_RATE_5 3'h5
`define HSW_RATE_2 3'h6
`define HSW_RATE_QUIET 3'h7

// Tick divisors for each rate
`define HSW_DIV_100 6'h01
`define HSW_DIV_50 6'h02
`define HSW_DIV_25 6'h04
`define HSW_DIV_20 6'h05
`define HSW_DIV_10 6'h0A
`define HSW_DIV_5 6'h14
`define HSW_DIV_2 6'h32

`endif

// [hdl/hsw_pkg.sv]
// Types of the health status word logic.
// Assumes hsw_defs.svh is on the include path.
`include "hsw_defs.svh"

package hsw_pkg;

    typedef enum logic [2:0] {
        HSW_ST_INIT = 3'b001,
        HSW_ST_RUN = 3'b010,
        HSW_ST_HOLD = 3'b100
    } hsw_state_e;

    // Status sources from the estimator and sensors
    typedef struct packed {
        logic fatal_int;
        logic hw_fault;
        logic link_fault;
        logic sw_fault;
        logic mag_align_bad;
        logic mag_cal_done;
        logic gps_acquired;
        logic gps_comm_lost;
        logic overrange;
        logic high_gain;
        logic utc_valid;
        logic signed [15:0] yaw_rate;
        logic signed [2:0][15:0] lp_rate;
    } hsw_src_s;

    // Host configuration; alert_en is {sensor, sw, link, hw}
    typedef struct packed {
        logic [3:0] alert_en;
        logic turn_alert_en;
        logic overrange_restart_enable;
        logic [2:0] rate_sel;
        logic turn_thr_wr;
        logic [15:0] turn_thr;
    } hsw_cfg_s;

    // Full subsystem status for the diagnostic packet
    typedef struct packed {
        logic [15:0] health;
        logic [2:0] state;
        logic mag_cal_done;
        logic gps_acquired;
        logic turning;
        logic quiet;
        logic init_phase;
    } hsw_diag_s;

endpackage

// [hdl/hsw_tick_gen.sv]
// 100 Hz update tick generator with UTC second alignment.
// Assumes utc_pps is an asynchronous pin from the positioning receiver.
`include "hsw_defs.svh"

module hsw_tick_gen
    import hsw_pkg::*;
#(
    parameter int TICK_CYCLES = `HSW_UPDATE_PERIOD_NS / `HSW_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Time reference
    input wire logic utc_pps,
    input wire logic utc_valid,
    // Tick out
    output logic tick
);

    logic pps_meta;
    logic pps_sync;
    logic pps_prev;
    logic [`HSW_TICK_W-1:0] cnt;
    logic pps_edge;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pps_meta <= 1'b0;
            pps_sync <= 1'b0;
            pps_prev <= 1'b0;
        end else begin
            pps_meta <= utc_pps;
            pps_sync <= pps_meta;
            pps_prev <= pps_sync;
        end
    end

    assign pps_edge = pps_sync & ~pps_prev;

    // Second edge restarts the cadence when utc_valid is set, so sampling lands on it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (pps_edge && utc_valid) begin
            cnt <= '0;
            tick <= 1'b1;
        end else if (cnt == `HSW_TICK_W'(TICK_CYCLES - 1)) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule

// [tb/hsw_host_model.sv]
// Host model: polls the device and counts the packets it receives.
// Assumes the device samples requests on the rising edge of clk.
module hsw_host_model
    import hsw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests to the device
    output logic get_packet_cmd,
    output logic get_diag,
    // Packets from the device
    input wire logic pkt_valid,
    input wire logic [15:0] pkt_health,
    input wire logic diag_valid,
    input wire hsw_diag_s diag_packet
);
    timeunit 1ns;
    timeprecision 1ps;

    int pkt_count;
    int diag_count;
    logic [15:0] last_health;
    hsw_diag_s last_diag;

    initial begin
        get_packet_cmd = 1'b0;
        get_diag = 1'b0;
    end

    always @(posedge clk) begin
        if (rst_n !== 1'b1) begin
            pkt_count = 0;
            diag_count = 0;
        end else begin
            if (pkt_valid === 1'b1) begin
                pkt_count++;
                last_health = pkt_health;
            end
            if (diag_valid === 1'b1) begin
                diag_count++;
                last_diag = diag_packet;
            end
        end
    end

    // Held high n cycles gives n back-to-back requests
    task automatic poll(input logic diag, input int n);
        @(negedge clk);
        get_packet_cmd = 1'b1;
        get_diag = diag;
        repeat (n) @(negedge clk);
        get_packet_cmd = 1'b0;
        get_diag = 1'b0;
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the health status word logic.
// Assumes short counts: 20 cycle tick, 4 tick init phase.
module testbench;
    import hsw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic utc_pps = 1'b0;
    hsw_src_s src;
    hsw_cfg_s cfg;
    logic get_packet_cmd, get_diag, pkt_valid, diag_valid;
    logic update_tick, init_phase, low_gain, algo_restart;
    logic [15:0] health_status_word, pkt_health;
    hsw_diag_s diag_packet;
    int fail_count = 0;
    int samples_checked = 0;
    int thr = 50;
    int n, c0, d0;
    int div[7] = '{1, 2, 4, 5, 10, 20, 50};
    logic signed [15:0] yaws[4] = '{16'sd50, 16'sd51, -16'sd51, -16'sd50};

    always #5 clk = ~clk;

    hsw_core #(.TICK_CYCLES(20), .INIT_TICKS(4), .NAV_VARIANT(1'b1)) i_dut (
        .clk(clk), .rst_n(rst_n), .src(src), .utc_pps(utc_pps), .cfg(cfg),
        .get_packet_cmd(get_packet_cmd), .get_diag(get_diag),
        .health_status_word(health_status_word), .pkt_valid(pkt_valid),
        .pkt_health(pkt_health), .diag_valid(diag_valid),
        .diag_packet(diag_packet), .update_tick(update_tick),
        .init_phase(init_phase), .low_gain(low_gain),
        .algo_restart(algo_restart));

    hsw_host_model i_host (
        .clk(clk), .rst_n(rst_n), .get_packet_cmd(get_packet_cmd),
        .get_diag(get_diag), .pkt_valid(pkt_valid), .pkt_health(pkt_health),
        .diag_valid(diag_valid), .diag_packet(diag_packet));

    task automatic tally_and_finish();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk16(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        samples_checked++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic wait_tick(output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (update_tick !== 1'b1 && k < 200);
        if (update_tick !== 1'b1) begin
            fail_count++;
            $display("Error update_tick never came");
            tally_and_finish();
        end
    endtask

    function automatic logic [15:0] exp_word(input logic ip, input logic hold);
        logic [15:0] w;
        int y;
        w = 16'h0000;
        y = int'(src.yaw_rate);
        if (y < 0) y = -y;
        w[0] = src.fatal_int | hold;
        w[1] = src.hw_fault;
        w[2] = src.link_fault;
        w[3] = src.sw_fault | src.mag_align_bad | ~src.mag_cal_done;
        w[9] = ~src.gps_acquired;
        w[10] = src.gps_comm_lost;
        w[11] = ip | src.high_gain | (cfg.turn_alert_en & (y > thr));
        w[12] = src.overrange;
        w[8] = |(w[12:9] & cfg.alert_en);
        return w;
    endfunction

    always @(negedge clk) begin
        if (rst_n === 1'b1) begin
            chk16("reserved", 16'h0000, health_status_word & 16'hE0F0);
            if (pkt_valid === 1'b1) begin
                chk16("pkt_health", health_status_word, pkt_health);
            end
        end
    end

    initial begin
        src = '0;
        src.mag_cal_done = 1'b1;
        src.gps_acquired = 1'b1;
        cfg = '0;
        cfg.alert_en = 4'hF;
        cfg.rate_sel = 3'h7;
        cyc(7);
        chk16("reset word", 16'h0000, health_status_word);
        chk16("reset phase", 16'h0002, {init_phase, low_gain});
        cyc(1);
        rst_n = 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 3) chk16("init word", exp_word(1, 0), health_status_word);
            if (n == 50) chk16("init phase", 16'h0001, init_phase);
        end while (init_phase !== 1'b0 && n < 300);
        chk_rng("init length", 70, 110, n);
        chk16("low gain", 16'h0001, low_gain);
        wait_tick(n);
        wait_tick(n);
        chk_rng("tick period", 20, 20, n);
        // Single-source walk over every flag field of src except utc_valid
        for (int i = 65; i <= 74; i++) begin
            src[i] = ~src[i];
            cyc(2);
            chk16("flag on", exp_word(0, 0), health_status_word);
            src[i] = ~src[i];
            cyc(2);
            chk16("flag off", exp_word(0, 0), health_status_word);
        end
        src.gps_acquired = 1'b0;
        src.gps_comm_lost = 1'b1;
        src.overrange = 1'b1;
        src.high_gain = 1'b1;
        for (int e = 0; e < 16; e++) begin
            cfg.alert_en = e[3:0];
            cyc(2);
            chk16("alert gate", exp_word(0, 0), health_status_word);
        end
        src = '0;
        src.mag_cal_done = 1'b1;
        src.gps_acquired = 1'b1;
        cfg.alert_en = 4'hF;
        cfg.turn_alert_en = 1'b1;
        for (int k = 0; k < 4; k++) begin
            src.yaw_rate = yaws[k];
            cyc(2);
            chk16("turn", exp_word(0, 0), health_status_word);
        end
        cfg.turn_thr = 16'h0064;
        cfg.turn_thr_wr = 1'b1;
        cyc(1);
        cfg.turn_thr_wr = 1'b0;
        thr = 100;
        for (int k = 100; k <= 101; k++) begin
            src.yaw_rate = k[15:0];
            cyc(2);
            chk16("turn thr", exp_word(0, 0), health_status_word);
        end
        src.yaw_rate = 16'h0000;
        for (int r = 0; r < 8; r++) begin
            cfg.rate_sel = r[2:0];
            wait_tick(n);
            wait_tick(n);
            c0 = i_host.pkt_count;
            repeat (100) wait_tick(n);
            n = (r == 7) ? 0 : 100 / div[r];
            chk_rng("paced packets", (r == 7) ? 0 : n - 1, (r == 7) ? 0 : n + 1, i_host.pkt_count - c0);
        end
        c0 = i_host.pkt_count;
        i_host.poll(1'b0, 3);
        cyc(2);
        chk_rng("polled packets", 3, 3, i_host.pkt_count - c0);
        chk16("polled health", exp_word(0, 0), i_host.last_health);
        c0 = i_host.pkt_count;
        d0 = i_host.diag_count;
        i_host.poll(1'b1, 1);
        cyc(2);
        chk_rng("diag packets", 1, 1, i_host.diag_count - d0);
        chk_rng("no plain packet", 0, 0, i_host.pkt_count - c0);
        chk16("diag health", exp_word(0, 0), i_host.last_diag.health);
        chk16("diag state", 16'h0002, 16'(i_host.last_diag.state));
        // Cal done, fix held, not turning, all axes quiet, init over
        chk16("diag flags", 16'h001A, 16'(i_host.last_diag[4:0]));
        // Second edge without a valid time reference must not realign
        wait_tick(n);
        cyc(7);
        utc_pps = 1'b1;
        wait_tick(n);
        chk_rng("pps ignored", 13, 13, n);
        utc_pps = 1'b0;
        src.utc_valid = 1'b1;
        cyc(7);
        utc_pps = 1'b1;
        wait_tick(n);
        chk_rng("pps align", 2, 7, n);
        utc_pps = 1'b0;
        wait_tick(n);
        chk_rng("aligned period", 20, 20, n);
        cfg.overrange_restart_enable = 1'b1;
        src.lp_rate = {16'sd1000, 16'sd1000, 16'sd1000};
        src.overrange = 1'b1;
        cyc(3);
        chk16("hold fatal", exp_word(1, 1), health_status_word);
        src.overrange = 1'b0;
        src.lp_rate = {16'sd0, 16'sd300, 16'sd0};
        cyc(5);
        chk16("still held", exp_word(1, 1), health_status_word);
        src.lp_rate = {16'sd299, -16'sd299, 16'sd0};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (algo_restart !== 1'b1 && n < 10);
        chk_rng("restart delay", 1, 4, n);
        cyc(2);
        chk16("restarted", exp_word(1, 0), health_status_word);
        tally_and_finish();
    end
endmodule
